//--- verilog/phy_mgmt_pkg.sv
// constants shared by the basic control and status register block
package phy_mgmt_pkg;

  // ----------------------------------------------------------------
  // management frame layout
  // ----------------------------------------------------------------
  localparam logic [4:0] PHY_ADDR = 5'h01;
  localparam logic [4:0] CTRL_REG_ADDR = 5'h00;
  localparam logic [4:0] STAT_REG_ADDR = 5'h01;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h09;
  localparam logic [4:0] DATA_LAST = 5'h0f;

  // ----------------------------------------------------------------
  // control word fields and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_AN_EN_BIT = 12;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_COLTEST_BIT = 7;
  localparam logic CTRL_AN_EN_RESET = 1'b1;
  localparam logic CTRL_ISOLATE_RESET = 1'b0;
  localparam logic CTRL_DUPLEX_RESET = 1'b1;
  localparam logic CTRL_COLTEST_RESET = 1'b0;
  localparam logic [15:0] CTRL_RESET = 16'h1100;

  // ----------------------------------------------------------------
  // status word fields and reset value
  // ----------------------------------------------------------------
  localparam int STAT_T4_BIT = 15;
  localparam int STAT_AN_DONE_BIT = 5;
  localparam int STAT_REMOTE_FAULT_BIT = 4;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_JABBER_BIT = 1;
  // bits 14..11, 6, 3 and 0 are fixed ones
  localparam logic [15:0] STAT_FIXED_ONES = 16'h7849;
  localparam logic [15:0] STAT_RESET = 16'h7849;

  // ----------------------------------------------------------------
  // collision self-check timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_TIME_NS = 10;
  localparam int COL_ON_BITS = 512;
  localparam int COL_OFF_BITS = 4;
  localparam int COL_ON_MAX_CYC = (COL_ON_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int COL_OFF_MAX_CYC = (COL_OFF_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;

endpackage

//--- verilog/bit_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module bit_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  always_comb begin
    s_d.meta = d_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.stable;
endmodule

//--- verilog/phy_basic_control_status.sv
// basic control and status words reached over the management serial link
`timescale 1ns/10ps

//
// What this block does
// - with collision self-check set and isolation off, COL rises well within 512 bit times of TX_EN rising.
// - with collision self-check set, COL falls within 4 bit times of TX_EN falling.
// - the duplex bit follows a write only when that write leaves auto-negotiation off, reset value full duplex.
// - isolation holds COL low and stops the reference clock in RMII master mode.
// - status bit 15 always reads zero.
// - status bits 14 to 11 always read one.
// - status bit 6 reads one, advertising preamble-less frames.
// - a full 32-bit preamble is required after reset or a bad start bit, opcode or turnaround, else not.
// - status bit 5 reads one only when auto-negotiation is enabled and has completed.
// - status bit 4 latches a remote fault and clears on a status read or reset.
// - status bit 3 always reads one.
// - status bit 2 shows the live link state, zero after reset.
// - status bit 1 latches jabber seen in 10BASE-T operation, zero after reset.
// - status bit 0 always reads one.
module phy_basic_control_status (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic tx_en_i,
  input wire logic an_complete_i,
  input wire logic link_up_i,
  input wire logic remote_fault_i,
  input wire logic jabber_i,
  input wire logic speed_10_i,
  input wire logic rmii_master_i,
  output logic col_o,
  output logic duplex_full_o,
  output logic isolate_o,
  output logic ref_clk_en_o,
  output logic an_enable_o
);
  import phy_mgmt_pkg::*;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_OP = 3'b010,
    M_ADDR = 3'b011,
    M_TA = 3'b100,
    M_DATA = 3'b101
  } mgmt_state_t;

  typedef struct packed {
    logic an_en;
    logic isolate;
    logic duplex;
    logic coltest;
    logic remote_fault;
    logic jabber;
    logic col;
    logic ref_en;
    logic [31:0] shadow;
    logic req;
    logic [1:0] acked_flags;
    logic wr_seen;
    logic rd_seen;
  } core_t;

  typedef struct packed {
    mgmt_state_t st;
    logic [4:0] cnt;
    logic [5:0] ones;
    logic need_pre;
    logic [1:0] op;
    logic [9:0] addr;
    logic [15:0] sh;
    logic [31:0] word;
    logic ack;
    logic wr_tgl;
    logic rd_tgl;
    logic [15:0] wr_data;
    logic mdio;
    logic oe;
  } mgmt_t;

  // ----------------------------------------------------------------
  // word builders
  // ----------------------------------------------------------------
  function automatic logic [15:0] status_word(input logic an_done, input logic rf,
                                              input logic link, input logic jab);
    logic [15:0] s;
    s = STAT_FIXED_ONES;
    s[STAT_T4_BIT] = 1'b0;
    s[STAT_AN_DONE_BIT] = an_done;
    s[STAT_REMOTE_FAULT_BIT] = rf;
    s[STAT_LINK_BIT] = link;
    s[STAT_JABBER_BIT] = jab;
    return s;
  endfunction

  function automatic logic [15:0] control_word(input core_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[CTRL_AN_EN_BIT] = c.an_en;
    w[CTRL_ISOLATE_BIT] = c.isolate;
    w[CTRL_DUPLEX_BIT] = c.duplex;
    w[CTRL_COLTEST_BIT] = c.coltest;
    return w;
  endfunction

  core_t c_q;
  core_t c_d;
  mgmt_t m_q;
  mgmt_t m_d;
  logic ack_sync, wr_sync, rd_sync, req_sync;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  bit_sync u_ack_sync (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(m_q.ack), .q_o(ack_sync));
  bit_sync u_wr_sync (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(m_q.wr_tgl), .q_o(wr_sync));
  bit_sync u_rd_sync (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(m_q.rd_tgl), .q_o(rd_sync));
  bit_sync u_req_sync (.clk_i(mdc_i), .rst_n_i(rst_n_i), .d_i(c_q.req), .q_o(req_sync));

  // ----------------------------------------------------------------
  // core clock domain: register state and side effects
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_ev;
    logic rd_ev;
    logic an_done;
    logic [15:0] wd;
    c_d = c_q;
    wr_ev = wr_sync != c_q.wr_seen;
    rd_ev = rd_sync != c_q.rd_seen;
    wd = m_q.wr_data;
    an_done = an_complete_i & c_q.an_en;
    c_d.wr_seen = wr_sync;
    c_d.rd_seen = rd_sync;
    // write data stays still for a whole frame after its toggle
    if (wr_ev) begin
      c_d.an_en = wd[CTRL_AN_EN_BIT];
      c_d.isolate = wd[CTRL_ISOLATE_BIT];
      c_d.coltest = wd[CTRL_COLTEST_BIT];
      if (!wd[CTRL_AN_EN_BIT]) begin
        c_d.duplex = wd[CTRL_DUPLEX_BIT];
      end
    end
    // sticky, clear on read, set wins
    c_d.remote_fault = (c_q.remote_fault & ~(rd_ev & c_q.acked_flags[1])) | remote_fault_i;
    c_d.jabber = (c_q.jabber & ~(rd_ev & c_q.acked_flags[0])) | (jabber_i & speed_10_i);
    // handshake: reload shadow once the copy on the mdc side has taken it
    if (ack_sync == c_q.req) begin
      // only flags the host actually saw may be cleared by its read
      c_d.acked_flags = {c_q.shadow[STAT_REMOTE_FAULT_BIT], c_q.shadow[STAT_JABBER_BIT]};
      c_d.shadow = {control_word(c_q),
                    status_word(an_done, c_q.remote_fault, link_up_i, c_q.jabber)};
      c_d.req = ~c_q.req;
    end
    // one-cycle response is far inside the on bound
    // and inside the two-cycle off bound
    c_d.col = c_q.coltest & tx_en_i & ~c_q.isolate;
    // reference clock stops only in master mode
    c_d.ref_en = ~(c_q.isolate & rmii_master_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_q <= '{an_en: CTRL_AN_EN_RESET, isolate: CTRL_ISOLATE_RESET,
               duplex: CTRL_DUPLEX_RESET, coltest: CTRL_COLTEST_RESET,
               remote_fault: 1'b0, jabber: 1'b0, col: 1'b0, ref_en: 1'b1,
               shadow: {CTRL_RESET, STAT_RESET}, req: 1'b0, acked_flags: 2'b00,
               wr_seen: 1'b0, rd_seen: 1'b0};
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // mdc domain: frame engine
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] rd_word;
    logic match;
    logic [4:0] regad;
    rd_word = 16'h0000;
    m_d = m_q;
    match = m_q.addr[9:5] == PHY_ADDR;
    regad = m_q.addr[4:0];
    if (regad == CTRL_REG_ADDR) begin
      rd_word = m_q.word[31:16];
    end else if (regad == STAT_REG_ADDR) begin
      rd_word = m_q.word[15:0];
    end
    if (req_sync != m_q.ack) begin
      m_d.word = c_q.shadow;
      m_d.ack = req_sync;
    end
    case (m_q.st)
      M_IDLE: begin
        m_d.oe = 1'b0;
        if (mdio_i) begin
          if (m_q.ones != PREAMBLE_BITS) begin
            m_d.ones = m_q.ones + 6'h01;
          end
        end else begin
          // short frames still need one idle high bit
          if (m_q.ones == PREAMBLE_BITS || (!m_q.need_pre && m_q.ones != 6'h00)) begin
            m_d.st = M_START;
            if (m_q.ones == PREAMBLE_BITS) begin
              m_d.need_pre = 1'b0;
            end
          end
          m_d.ones = 6'h00;
        end
      end
      M_START: begin
        m_d.cnt = 5'h00;
        if (mdio_i) begin
          m_d.st = M_OP;
        end else begin
          m_d.need_pre = 1'b1;
          m_d.st = M_IDLE;
        end
      end
      M_OP: begin
        m_d.op = {m_q.op[0], mdio_i};
        if (m_q.cnt == OP_LAST) begin
          m_d.st = M_ADDR;
          m_d.cnt = 5'h00;
        end else begin
          m_d.cnt = m_q.cnt + 5'h01;
        end
      end
      M_ADDR: begin
        m_d.addr = {m_q.addr[8:0], mdio_i};
        if (m_q.cnt == ADDR_LAST) begin
          m_d.cnt = 5'h00;
          // bad opcode forces a full preamble next
          if (m_q.op != OP_READ && m_q.op != OP_WRITE) begin
            m_d.need_pre = 1'b1;
            m_d.st = M_IDLE;
          end else begin
            m_d.st = M_TA;
          end
        end else begin
          m_d.cnt = m_q.cnt + 5'h01;
        end
      end
      M_TA: begin
        if (m_q.op == OP_READ) begin
          if (m_q.cnt == 5'h00) begin
            m_d.cnt = 5'h01;
            m_d.oe = match;
            m_d.mdio = 1'b0;
          end else begin
            m_d.st = M_DATA;
            m_d.cnt = 5'h00;
            m_d.mdio = rd_word[15];
            m_d.sh = {rd_word[14:0], 1'b0};
            // status read clears the latched flags
            if (match && regad == STAT_REG_ADDR) begin
              m_d.rd_tgl = ~m_q.rd_tgl;
            end
          end
        end else if ((m_q.cnt == 5'h00) != mdio_i) begin
          // bad turnaround forces a full preamble next
          m_d.need_pre = 1'b1;
          m_d.st = M_IDLE;
        end else if (m_q.cnt == 5'h00) begin
          m_d.cnt = 5'h01;
        end else begin
          m_d.st = M_DATA;
          m_d.cnt = 5'h00;
        end
      end
      M_DATA: begin
        if (m_q.op == OP_READ) begin
          m_d.mdio = m_q.sh[15];
          m_d.sh = {m_q.sh[14:0], 1'b0};
        end else begin
          m_d.sh = {m_q.sh[14:0], mdio_i};
        end
        if (m_q.cnt == DATA_LAST) begin
          m_d.st = M_IDLE;
          m_d.oe = 1'b0;
          m_d.ones = 6'h00;
          if (m_q.op == OP_WRITE && match && regad == CTRL_REG_ADDR) begin
            m_d.wr_data = {m_q.sh[14:0], mdio_i};
            m_d.wr_tgl = ~m_q.wr_tgl;
          end
        end else begin
          m_d.cnt = m_q.cnt + 5'h01;
        end
      end
      default: begin
        m_d.st = M_IDLE;
        m_d.oe = 1'b0;
      end
    endcase
  end

  // mdc may stop between frames, so nothing here waits on a later edge
  always_ff @(posedge mdc_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m_q <= '{st: M_IDLE, cnt: 5'h00, ones: 6'h00, need_pre: 1'b1, op: 2'b00,
               addr: 10'h000, sh: 16'h0000, word: {CTRL_RESET, STAT_RESET},
               ack: 1'b0, wr_tgl: 1'b0, rd_tgl: 1'b0, wr_data: CTRL_RESET,
               mdio: 1'b0, oe: 1'b0};
    end else begin
      m_q <= m_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mdio_o = m_q.mdio;
  assign mdio_oe_o = m_q.oe;
  assign col_o = c_q.col;
  assign duplex_full_o = c_q.duplex;
  assign isolate_o = c_q.isolate;
  assign ref_clk_en_o = c_q.ref_en;
  assign an_enable_o = c_q.an_en;
endmodule

//--- tb/phy_basic_control_status_sva.sv
// port assertions for the basic control and status block
`timescale 1ns/10ps
module phy_basic_control_status_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic tx_en_i,
  input wire logic an_complete_i,
  input wire logic link_up_i,
  input wire logic remote_fault_i,
  input wire logic jabber_i,
  input wire logic speed_10_i,
  input wire logic rmii_master_i,
  input wire logic col_o,
  input wire logic duplex_full_o,
  input wire logic isolate_o,
  input wire logic ref_clk_en_o,
  input wire logic an_enable_o
);
  // ----------------------------------------------------------------
  // read answer: turnaround zero, then sixteen driven bits
  // ----------------------------------------------------------------
  sequence s_turn_zero;
    mdio_oe_o && !mdio_o;
  endsequence
  sequence s_data_span;
    mdio_oe_o [*8] ##1 mdio_oe_o [*8] ##1 !mdio_oe_o;
  endsequence

  a_read_span: assert property (@(posedge mdc_i) disable iff (!rst_n_i)
    $rose(mdio_oe_o) |-> s_turn_zero ##1 s_data_span) else $error("read drive span wrong");
  a_col_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    col_o |-> $past(tx_en_i) && !$past(isolate_o)) else $error("col without transmit");
  a_col_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tx_en_i |=> !col_o) else $error("col held after transmit end");
  a_iso_col: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    isolate_o |=> !col_o) else $error("col while isolated");
  a_ref_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    isolate_o && rmii_master_i |=> !ref_clk_en_o) else $error("ref clock not stopped");
  a_ref_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(isolate_o && rmii_master_i) |=> ref_clk_en_o) else $error("ref clock stopped");
  a_reset_vals: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> duplex_full_o && an_enable_o && !isolate_o && ref_clk_en_o && !col_o)
    else $error("wrong values after reset");
  a_duplex_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(duplex_full_o) |-> !an_enable_o) else $error("duplex moved with autoneg on");
endmodule

bind phy_basic_control_status phy_basic_control_status_sva phy_basic_control_status_sva_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
  .mdio_oe_o(mdio_oe_o), .tx_en_i(tx_en_i), .an_complete_i(an_complete_i),
  .link_up_i(link_up_i), .remote_fault_i(remote_fault_i), .jabber_i(jabber_i),
  .speed_10_i(speed_10_i), .rmii_master_i(rmii_master_i), .col_o(col_o),
  .duplex_full_o(duplex_full_o), .isolate_o(isolate_o), .ref_clk_en_o(ref_clk_en_o),
  .an_enable_o(an_enable_o));

//--- tb/mgmt_host_model.sv
// management host model driving the two-wire management link
`timescale 1ns/10ps
module mgmt_host_model (
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  import phy_mgmt_pkg::*;

  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // one bit; clock only runs inside frames, sampled just before the rise
  task automatic bit_cycle(input logic b, input logic drv, output logic s);
    mdio_o = b;
    mdio_oe_o = drv;
    #24;
    s = mdio_i;
    mdc_o = 1'b1;
    #24;
    mdc_o = 1'b0;
  endtask

  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [14:0] hdr;
    logic [17:0] tail;
    logic s;
    hdr = {1'b1, 2'b01, op, PHY_ADDR, ra};
    tail = {2'b10, wd};
    rd = 16'h0000;
    #500;
    if (pre) begin
      for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
    end
    for (int i = 14; i >= 0; i--) bit_cycle(hdr[i], 1'b1, s);
    for (int i = 17; i >= 0; i--) begin
      bit_cycle(tail[i], op != OP_READ, s);
      if (i < 16) rd[i] = s;
    end
    mdio_oe_o = 1'b0;
  endtask
endmodule

//--- tb/phy_basic_control_status_tb_top.sv
// self-checking bench for the basic control and status block
`timescale 1ns/10ps
module phy_basic_control_status_tb_top;
  import phy_mgmt_pkg::*;
  logic clk_i, rst_n_i, mdc_i, mdio_i, mdio_o, mdio_oe_o, host_d, host_oe, s;
  logic tx_en_i, an_complete_i, link_up_i, remote_fault_i, jabber_i, speed_10_i;
  logic rmii_master_i, col_o, duplex_full_o, isolate_o, ref_clk_en_o, an_enable_o;
  logic an_on, dup;
  logic [15:0] rd;
  int fails, n_compared;

  // pull-up on the shared data line
  assign mdio_i = mdio_oe_o ? mdio_o : (host_oe ? host_d : 1'b1);

  phy_basic_control_status phy_basic_control_status_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .tx_en_i(tx_en_i), .an_complete_i(an_complete_i),
    .link_up_i(link_up_i), .remote_fault_i(remote_fault_i), .jabber_i(jabber_i),
    .speed_10_i(speed_10_i), .rmii_master_i(rmii_master_i), .col_o(col_o),
    .duplex_full_o(duplex_full_o), .isolate_o(isolate_o), .ref_clk_en_o(ref_clk_en_o),
    .an_enable_o(an_enable_o));
  mgmt_host_model mgmt_host_model_inst (
    .mdio_i(mdio_i), .mdc_o(mdc_i), .mdio_o(host_d), .mdio_oe_o(host_oe));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_stat(input logic anc, lk, rf, jb);
    exp_stat = STAT_FIXED_ONES;
    exp_stat[STAT_AN_DONE_BIT] = anc & an_on;
    exp_stat[STAT_REMOTE_FAULT_BIT] = rf;
    exp_stat[STAT_LINK_BIT] = lk;
    exp_stat[STAT_JABBER_BIT] = jb;
  endfunction

  task automatic rw(input logic pre, input logic [1:0] op, input logic [4:0] ra,
                    input logic [15:0] wd);
    mgmt_host_model_inst.frame(pre, op, ra, wd, rd);
  endtask

  task automatic rand_status(input int n);
    logic anc, lk, rf, jb, s10;
    repeat (n) begin
      {anc, lk, rf, jb, s10} = 5'($urandom);
      @(posedge clk_i);
      an_complete_i <= anc;
      link_up_i <= lk;
      remote_fault_i <= rf;
      jabber_i <= jb;
      speed_10_i <= s10;
      @(posedge clk_i);
      remote_fault_i <= 1'b0;
      jabber_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rw(1'b0, OP_READ, STAT_REG_ADDR, 16'h0000);
      chk(rd, exp_stat(anc, lk, rf, jb & s10));
      rw(1'b0, OP_READ, STAT_REG_ADDR, 16'h0000);
      chk(rd, exp_stat(anc, lk, 1'b0, 1'b0));
    end
  endtask

  task automatic wr_ctrl(input logic [15:0] w);
    rw(1'b0, OP_WRITE, CTRL_REG_ADDR, w);
    an_on = w[CTRL_AN_EN_BIT];
    if (!an_on) dup = w[CTRL_DUPLEX_BIT];
    repeat (10) @(posedge clk_i);
    chk({13'h0, an_enable_o, duplex_full_o, isolate_o}, {13'h0, an_on, dup, w[10]});
    chk({15'h0, ref_clk_en_o}, {15'h0, !(w[10] && rmii_master_i)});
    rw(1'b0, OP_READ, CTRL_REG_ADDR, 16'h0000);
    chk(rd, (w & 16'h1480) | {7'h0, dup, 8'h00});
  endtask

  task automatic col_pulse(input logic on, input int n);
    @(posedge clk_i);
    tx_en_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    tx_en_i <= 1'b0;
    #1;
    chk({15'h0, col_o}, {15'h0, on});
    @(posedge clk_i);
    #1;
    chk({15'h0, col_o}, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, tx_en_i, an_complete_i, link_up_i, remote_fault_i} = 5'h00;
    {jabber_i, speed_10_i, rmii_master_i} = 3'h0;
    fails = 0;
    n_compared = 0;
    an_on = 1'b1;
    dup = 1'b1;
    void'($urandom(19959));
    mgmt_host_model_inst.bit_cycle(1'b1, 1'b0, s);
    mgmt_host_model_inst.bit_cycle(1'b1, 1'b0, s);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({11'h0, duplex_full_o, an_enable_o, isolate_o, ref_clk_en_o, col_o}, 16'h001a);
    repeat (20) @(posedge clk_i);
    rw(1'b1, OP_READ, STAT_REG_ADDR, 16'h0000);
    chk(rd, STAT_RESET);
    rw(1'b0, OP_READ, CTRL_REG_ADDR, 16'h0000);
    chk(rd, CTRL_RESET);
    rw(1'b0, OP_READ, 5'h05, 16'h0000);
    chk(rd, 16'h0000);
    rand_status(6);
    // bad opcode: short frames refused until a full preamble
    rw(1'b0, 2'b11, STAT_REG_ADDR, 16'h0000);
    rw(1'b0, OP_READ, STAT_REG_ADDR, 16'h0000);
    chk(rd, 16'hffff);
    rw(1'b1, OP_READ, STAT_REG_ADDR, 16'h0000);
    chk(rd, exp_stat(an_complete_i, link_up_i, 1'b0, 1'b0));
    wr_ctrl(16'h0080);
    rand_status(4);
    col_pulse(1'b1, 1);
    col_pulse(1'b1, 1 + $urandom % 8);
    wr_ctrl(16'h1180);
    wr_ctrl(16'h0180);
    @(posedge clk_i);
    rmii_master_i <= 1'b1;
    wr_ctrl(16'h0480);
    col_pulse(1'b0, 3);
    @(posedge clk_i);
    rmii_master_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({15'h0, ref_clk_en_o}, 16'h0001);
    test_done();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #400_000;
    fails++;
    test_done();
  end
endmodule
